// [dsl_rx_pkg.sv]
package dsl_rx_pkg;
  // Register word indices, byte address is four times the index
  localparam logic [7:0] IDX_OPS_LOW = 8'h61;
  localparam logic [7:0] IDX_CMD1 = 8'h90;
  localparam logic [7:0] IDX_CMD2 = 8'h91;
  localparam logic [7:0] IDX_BLK_BITS = 8'h92;
  localparam logic [7:0] IDX_SBITS = 8'h93;
  localparam logic [7:0] IDX_SYNC = 8'hA1;
  localparam logic [7:0] IDX_COMMON1 = 8'hC0;
  localparam logic [7:0] IDX_RESYNC = 8'hD8;
  localparam logic [7:0] IDX_OPS_HIGH = 8'hE0;
  localparam logic [7:0] IDX_IND_A = 8'hE2;
  localparam logic [7:0] IDX_IND_B = 8'hE3;
  localparam logic [7:0] IDX_SIG = 8'hE4;
  localparam logic [7:0] IDX_STAT1 = 8'hE5;
  localparam logic [7:0] IDX_STAT2 = 8'hE6;
  localparam logic [7:0] IDX_TALLY = 8'hE8;
  // Field positions
  localparam int ACQ_LSB = 0;
  localparam int LOSE_LSB = 3;
  localparam int TOL_LSB = 0;
  localparam int DSC_SEL_BIT = 4;
  localparam int DSC_EN_BIT = 5;
  localparam int RATE_LSB = 0;
  // Reset values of the control fields
  localparam logic [2:0] ACQ_RST = 3'h2;
  localparam logic [2:0] LOSE_RST = 3'h6;
  localparam logic [3:0] TOL_RST = 4'hC;
  localparam logic [7:0] BLK_BITS_RST = 8'h08;
  localparam logic [3:0] SBITS_RST = 4'h0;
  localparam logic [13:0] SYNC_RST_VAL = 14'h0000;
  // Frame geometry, in bits after the sync word
  localparam int SYNC_W = 14;
  localparam logic [13:0] SIGN_MASK = 14'h2AAA;
  localparam logic [15:0] IND_HEAD = 16'h0002;
  localparam logic [15:0] OH_SEG = 16'h000A;
  localparam logic [15:0] BLKS_PER_GROUP = 16'h000C;
  localparam logic [15:0] STUFF_BITS = 16'h0004;
  localparam logic [15:0] SIDE = 16'h0002;
  localparam logic [15:0] SYNC_LAST = 16'h000D;
  localparam logic [15:0] CRC_OFF0 = 16'h0004;
  localparam logic [15:0] CRC_OFF1 = 16'h0005;
  localparam logic [15:0] EOC_OFF_MAX = 16'h0003;
  localparam logic [15:0] IND_OFF_MIN = 16'h0006;
  localparam logic [15:0] EOC5_OFF = 16'h0009;
  // Signal buffer refresh in blocks: 6, 3, 2, 1 ms of a 48-block frame
  localparam logic [3:0][5:0] SIG_BLKS = {6'h08, 6'h10, 6'h18, 6'h30};
  localparam logic [13:0] CRC_POLY = 14'h0003;

  typedef enum logic [1:0] {ST_HUNT, ST_CONFIRM, ST_LOCKED, ST_FALTER} frm_state_t;

  typedef struct packed {
    logic [2:0] acq;
    logic [2:0] lose;
    logic [3:0] tol;
    logic dsc_en;
    logic dsc_sel;
    logic [7:0] blk_bits;
    logic [3:0] sbits;
    logic [1:0] rate;
    logic [13:0] sync;
  } cfg_t;

  typedef struct packed {
    logic valid;
    logic data;
  } bit_ev_t;
endpackage

// [crc6_check.sv]
`timescale 1ns/100ps
// Serial remainder for x^6+x+1, first covered bit is the highest power
module crc6_check
  import dsl_rx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input bit_ev_t din,
  output logic [5:0] rem_o
);
  logic [5:0] crc_r; // Running remainder
  logic fb; // Feedback bit
  logic [5:0] upd; // Remainder after this bit

  assign fb = din.data ^ crc_r[5];
  assign upd = {crc_r[4:0], 1'b0} ^ (fb ? CRC_POLY[5:0] : 6'h00);
  // Includes the bit arriving now, so frame end sees the last bit
  assign rem_o = din.valid ? upd : crc_r;

  // Clear wins at the frame boundary
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_r <= 6'h00;
    end else if (clr) begin
      crc_r <= 6'h00;
    end else if (din.valid) begin
      crc_r <= upd;
    end
  end
endmodule

// [lfsr23_descrambler.sv]
`timescale 1ns/100ps
// Self-synchronising 23-stage descrambler, one stage per received bit
module lfsr23_descrambler
  import dsl_rx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic sel,
  input bit_ev_t din,
  output logic dout
);
  logic [22:0] stg_r; // Past received line bits
  logic tap; // Selected inner tap

  // Inner tap 18 or 5, outer tap always 23
  assign tap = sel ? stg_r[4] : stg_r[17];
  assign dout = enable ? (din.data ^ tap ^ stg_r[22]) : din.data;

  // Shift in the scrambled line bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stg_r <= 23'h000000;
    end else if (din.valid) begin
      stg_r <= {stg_r[21:0], din.data};
    end
  end
endmodule

// [dsl_frame_receiver.sv]
`timescale 1ns/100ps
// Function
// - Sign/magnitude pairs map to four quats
// - Frame tick once per frame after sync
// - Resync write forces hunting state
// - Hunt compares pattern at every bit
// - Sign-inverted pattern also accepted
// - Inverted find sets flag, inverts signs
// - Confirm checks two stuff-dependent positions
// - Count confirms, lock at acquire setting
// - Confirm miss returns to hunting
// - Locked drops to faltering on error, to hunting if lose setting is 0 or 1
// - Faltering uses tolerance, widens search
// - Faltering counts misses to lose setting
// - Exact sync while faltering relocks
// - Check bits compared with previous CRC
// - Error sets flag, bumps tally
// - Same CRC as transmit side
// - Optional descramble except sync word
// - 23-stage descrambler, taps selectable
// - Overhead bits demuxed into registers
// - Signal buffer refresh at 3/2/1 ms points within a frame, none at frame end, so none at the 6 ms setting
// - Sync word is fourteen bits
// - Zero or four stuff bits
// - 48 blocks in four groups
// - CRC x^6+x+1 skips sync, stuff, check
module dsl_frame_receiver
  import dsl_rx_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic BIT_CLK_IN,
  input wire logic RX_LINE_DATA,
  output logic RX_FRAME_TICK
);
  // Bus side
  logic [7:0] idx; // Word index
  logic acc_done; // Completing access edge
  logic wr_done; // Write takes effect
  logic rd_done; // Read data taken
  logic [15:0] rd_word; // Read mux
  logic mapped; // Known index
  logic pready_r; // Answer one cycle into access
  logic [31:0] prdata_r; // Read data
  logic pslverr_r; // Unmapped answer
  cfg_t cfg_r; // Control registers
  logic resync; // Resync strobe write

  // Link sampling
  logic clk_s1_r, clk_s2_r, clk_s3_r; // Bit clock synchroniser
  logic dat_s1_r, dat_s2_r; // Line data synchroniser
  logic step; // Rising bit clock edge
  logic raw; // Line bit as received

  // Framer
  frm_state_t st_r, st_nxt; // Sync state
  logic [2:0] cnt_r, cnt_nxt; // State count
  logic [15:0] p_r, p_nxt; // Bits since last sync end
  logic pol_r, pol_nxt; // Line polarity swapped
  logic side_r, side_nxt; // Early side match seen
  logic [13:0] sr_r, sr_n; // Last 14 raw bits
  logic [13:0] exp_w; // Expected sync form
  logic exact; // Full match
  logic tolm; // Match within tolerance
  logic [4:0] agree; // Agreeing bits
  logic [3:0] cnt_inc; // Count plus one
  logic [15:0] g, s1, s2, s3, endp, pn0, pn1; // Frame positions
  logic at_pn; // One of the two sync positions

  // Data path
  logic live; // Not hunting
  logic in_data; // Before the next sync
  logic in1, in2, in3, in_oh, head; // Overhead regions
  logic [15:0] off; // Offset in overhead segment
  logic crc_bit; // Check bit position
  logic payload; // Payload block bit
  logic corr; // Polarity-corrected bit
  logic d; // Descrambled bit
  logic fe; // Last bit of frame
  logic [5:0] rem; // CRC over this frame
  logic err; // Block error at frame end
  logic [2:0] quat_r; // Last decoded symbol
  logic sgn_r; // Sign half of pair
  logic [12:0] ind_w_r, ind_w_nxt, ind_r; // Indicator work and visible
  logic [12:0] eoc_w_r, eoc_w_nxt, eoc_r; // Ops channel work and visible
  logic [5:0] crcrx_r; // Received check bits
  logic [5:0] pcrc_r; // CRC of previous frame
  logic pvalid_r; // Previous frame exists
  logic errflag_r; // Block error flag
  logic [7:0] tally_r, tally_nxt; // Block error tally
  logic [7:0] bb_r; // Bit in block
  logic [5:0] sigcnt_r; // Blocks since signal update
  logic [7:0] sigw_r, sig_r; // Signal bits work and visible
  logic blk_end; // Last bit of a block
  logic sig_upd; // Signal refresh point
  logic tick_r; // Frame tick
  bit_ev_t dsc_in, crc_in; // Bit events to sub-blocks

  // 2B1Q mapping of sign and magnitude
  function automatic logic [2:0] quat(input logic s, input logic m);
    unique case ({s, m})
      2'b10: quat = 3'h3;
      2'b11: quat = 3'h1;
      2'b01: quat = 3'h7;
      2'b00: quat = 3'h5;
    endcase
  endfunction

  // Count of agreeing bits
  function automatic logic [4:0] ones(input logic [13:0] v);
    ones = 5'h00;
    for (int i = 0; i < SYNC_W; i++) begin
      ones = ones + {4'h0, v[i]};
    end
  endfunction

  // Bus decode
  assign idx = PADDR[9:2];
  assign acc_done = PSEL & PENABLE & pready_r;
  assign wr_done = acc_done & PWRITE;
  assign rd_done = acc_done & ~PWRITE;
  assign resync = wr_done & (idx == IDX_RESYNC);
  assign mapped = (idx == IDX_OPS_LOW) | (idx == IDX_CMD1) | (idx == IDX_CMD2)
    | (idx == IDX_BLK_BITS) | (idx == IDX_SBITS) | (idx == IDX_SYNC)
    | (idx == IDX_COMMON1) | (idx == IDX_RESYNC) | (idx == IDX_OPS_HIGH)
    | (idx == IDX_IND_A) | (idx == IDX_IND_B) | (idx == IDX_SIG)
    | (idx == IDX_STAT1) | (idx == IDX_STAT2) | (idx == IDX_TALLY);
  assign rd_word = (idx == IDX_OPS_LOW) ? {8'h00, eoc_r[7:0]}
    : (idx == IDX_CMD1) ? {10'h000, cfg_r.lose, cfg_r.acq}
    : (idx == IDX_CMD2) ? {10'h000, cfg_r.dsc_en, cfg_r.dsc_sel, cfg_r.tol}
    : (idx == IDX_BLK_BITS) ? {8'h00, cfg_r.blk_bits}
    : (idx == IDX_SBITS) ? {12'h000, cfg_r.sbits}
    : (idx == IDX_SYNC) ? {2'h0, cfg_r.sync}
    : (idx == IDX_COMMON1) ? {14'h0000, cfg_r.rate}
    : (idx == IDX_OPS_HIGH) ? {11'h000, eoc_r[12:8]}
    : (idx == IDX_IND_A) ? {8'h00, ind_r[7:0]}
    : (idx == IDX_IND_B) ? {11'h000, ind_r[12:8]}
    : (idx == IDX_SIG) ? {8'h00, sig_r}
    : (idx == IDX_STAT1) ? {9'h000, pol_r, st_r, 1'b0, quat_r}
    : (idx == IDX_STAT2) ? {10'h000, errflag_r, 2'h0, cnt_r}
    : (idx == IDX_TALLY) ? {8'h00, tally_r} : 16'h0000;

  // Answer: ready one cycle after access phase opens
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= PSEL & PENABLE & ~pready_r;
      // Error stands only with ready, never after it
      pslverr_r <= PSEL & PENABLE & ~pready_r & ~mapped;
      // Read data moves only on reads, writes leave it standing
      if (PSEL & PENABLE & ~pready_r & ~PWRITE) begin
        prdata_r <= {16'h0000, rd_word};
      end
    end
  end

  // Control register writes
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cfg_r <= '{ACQ_RST, LOSE_RST, TOL_RST, 1'b0, 1'b0, BLK_BITS_RST, SBITS_RST,
        2'h0, SYNC_RST_VAL};
    end else if (wr_done) begin
      if (idx == IDX_CMD1) begin
        cfg_r.acq <= PWDATA[ACQ_LSB +: 3];
        cfg_r.lose <= PWDATA[LOSE_LSB +: 3];
      end
      if (idx == IDX_CMD2) begin
        cfg_r.tol <= PWDATA[TOL_LSB +: 4];
        cfg_r.dsc_sel <= PWDATA[DSC_SEL_BIT];
        cfg_r.dsc_en <= PWDATA[DSC_EN_BIT];
      end
      if (idx == IDX_BLK_BITS) begin
        cfg_r.blk_bits <= PWDATA[7:0];
      end
      if (idx == IDX_SBITS) begin
        cfg_r.sbits <= PWDATA[3:0];
      end
      if (idx == IDX_SYNC) begin
        cfg_r.sync <= PWDATA[13:0];
      end
      if (idx == IDX_COMMON1) begin
        cfg_r.rate <= PWDATA[RATE_LSB +: 2];
      end
    end
  end

  // Bit clock and data pass two flops before use
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      {clk_s1_r, clk_s2_r, clk_s3_r, dat_s1_r, dat_s2_r} <= 5'h00;
    end else begin
      {clk_s1_r, clk_s2_r, clk_s3_r} <= {BIT_CLK_IN, clk_s1_r, clk_s2_r};
      {dat_s1_r, dat_s2_r} <= {RX_LINE_DATA, dat_s1_r};
    end
  end
  assign step = clk_s2_r & ~clk_s3_r;
  assign raw = dat_s2_r;

  // four groups of twelve blocks with overhead between
  assign g = 16'(cfg_r.blk_bits) * BLKS_PER_GROUP;
  assign s1 = IND_HEAD + g;
  assign s2 = s1 + OH_SEG + g;
  assign s3 = s2 + OH_SEG + g;
  assign endp = s3 + OH_SEG + g;
  // nominal end or four stuff bits later
  assign pn0 = endp + SYNC_LAST;
  assign pn1 = pn0 + STUFF_BITS;
  assign at_pn = (p_r == pn0) | (p_r == pn1);
  assign sr_n = {sr_r[12:0], raw};
  assign exp_w = pol_r ? (cfg_r.sync ^ SIGN_MASK) : cfg_r.sync;
  assign exact = (sr_n == exp_w);
  assign agree = ones(~(sr_n ^ exp_w));
  assign tolm = (agree >= {1'b0, cfg_r.tol});
  assign cnt_inc = {1'b0, cnt_r} + 4'h1;

  // Framer next state
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    p_nxt = step ? (p_r + 16'h0001) : p_r;
    pol_nxt = pol_r;
    side_nxt = side_r;
    if (step) begin
      unique case (st_r)
        ST_HUNT: begin
          if ((sr_n == cfg_r.sync) || (sr_n == (cfg_r.sync ^ SIGN_MASK))) begin
            st_nxt = ST_CONFIRM;
            cnt_nxt = 3'h0;
            pol_nxt = (sr_n != cfg_r.sync);
            p_nxt = 16'h0000;
          end
        end
        ST_CONFIRM: begin
          if (at_pn && exact) begin
            p_nxt = 16'h0000;
            if (cnt_inc >= {1'b0, cfg_r.acq}) begin
              st_nxt = ST_LOCKED;
              cnt_nxt = 3'h0;
            end else begin
              cnt_nxt = cnt_inc[2:0];
            end
          end else if (p_r == pn1) begin
            st_nxt = ST_HUNT;
            cnt_nxt = 3'h0;
          end
        end
        ST_LOCKED: begin
          if (at_pn && exact) begin
            p_nxt = 16'h0000;
          end else if (p_r == pn1) begin
            st_nxt = (cfg_r.lose <= 3'h1) ? ST_HUNT : ST_FALTER;
            cnt_nxt = 3'h1;
            p_nxt = STUFF_BITS;
            side_nxt = 1'b0;
          end
        end
        ST_FALTER: begin
          if (at_pn && exact) begin
            st_nxt = ST_LOCKED;
            cnt_nxt = 3'h0;
            p_nxt = 16'h0000;
            side_nxt = 1'b0;
          end else if (at_pn && tolm) begin
            p_nxt = 16'h0000;
            side_nxt = 1'b0;
          end else if ((p_r == pn0 - SIDE) && tolm) begin
            // early side quat, kept for later
            side_nxt = 1'b1;
          end else if ((p_r == pn0) && side_r) begin
            p_nxt = SIDE;
            side_nxt = 1'b0;
          end else if (((p_r == pn0 + SIDE) || (p_r == pn1 + SIDE)) && tolm) begin
            p_nxt = 16'h0000;
            side_nxt = 1'b0;
          end else if (p_r == pn1 + SIDE) begin
            cnt_nxt = cnt_inc[2:0];
            st_nxt = (cnt_inc >= {1'b0, cfg_r.lose}) ? ST_HUNT : ST_FALTER;
            p_nxt = STUFF_BITS + SIDE;
            side_nxt = 1'b0;
          end
        end
      endcase
    end
    if (resync) begin
      st_nxt = ST_HUNT;
      cnt_nxt = 3'h0;
    end
  end

  // Framer registers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_r <= ST_HUNT;
      {cnt_r, p_r, pol_r, side_r, sr_r} <= 35'h000000000;
    end else begin
      st_r <= st_nxt;
      {cnt_r, p_r, pol_r, side_r} <= {cnt_nxt, p_nxt, pol_nxt, side_nxt};
      if (step) begin
        sr_r <= sr_n;
      end
    end
  end

  // Frame regions
  assign live = (st_r != ST_HUNT);
  assign in_data = (p_r < endp);
  assign head = (p_r < IND_HEAD);
  assign in1 = (p_r >= s1) && (p_r < s1 + OH_SEG);
  assign in2 = (p_r >= s2) && (p_r < s2 + OH_SEG);
  assign in3 = (p_r >= s3) && (p_r < s3 + OH_SEG);
  assign in_oh = in1 | in2 | in3;
  assign off = in1 ? (p_r - s1) : in2 ? (p_r - s2) : (p_r - s3);
  assign crc_bit = in_oh && ((off == CRC_OFF0) || (off == CRC_OFF1));
  assign payload = in_data & ~head & ~in_oh;
  // sign bits inverted on a swapped line
  assign corr = raw ^ (pol_r & ~p_r[0]);
  // sync and stuff bits bypass the descrambler
  assign dsc_in = '{step & live & in_data, corr};
  // sync, stuff and check bits not covered
  assign crc_in = '{step & live & in_data & ~crc_bit, d};
  assign fe = step & live & (p_r == endp - 16'h0001);
  // current check bits against previous frame
  assign err = fe & pvalid_r & (crcrx_r != pcrc_r);
  assign blk_end = step & live & payload & (bb_r == cfg_r.blk_bits - 8'h01);
  assign sig_upd = blk_end & ((sigcnt_r + 6'h01) == SIG_BLKS[cfg_r.rate]);

  lfsr23_descrambler u_dsc (
    .clk(CLOCK),
    .rst(RST),
    .enable(cfg_r.dsc_en),
    .sel(cfg_r.dsc_sel),
    .din(dsc_in),
    .dout(d)
  );

  // same remainder as the transmit generator
  crc6_check u_crc (
    .clk(CLOCK),
    .rst(RST),
    .clr(fe | ~live),
    .din(crc_in),
    .rem_o(rem)
  );

  always_comb begin
    ind_w_nxt = ind_w_r;
    eoc_w_nxt = eoc_w_r;
    if (step && live && in_data) begin
      if (head) begin
        ind_w_nxt[4'(16'hC - p_r)] = d;
      end else if (in_oh && (off <= EOC_OFF_MAX)) begin
        eoc_w_nxt[4'((in1 ? 16'hC : in2 ? 16'h7 : 16'h3) - off)] = d;
      end else if (in1 && (off == EOC5_OFF)) begin
        eoc_w_nxt[8] = d;
      end else if (in_oh && (off >= IND_OFF_MIN)) begin
        ind_w_nxt[4'((in1 ? 16'h10 : in2 ? 16'hD : 16'h9) - off)] = d;
      end
    end
  end

  // Block error tally clears on read, a new error wins
  assign tally_nxt = (rd_done && (idx == IDX_TALLY)) ? 8'h00 : tally_r;

  // Frame-end processing, CRC and error count
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      {pcrc_r, crcrx_r, pvalid_r, errflag_r, tally_r, tick_r} <= 23'h000000;
    end else begin
      tick_r <= fe;
      if (step && live && crc_bit) begin
        crcrx_r <= {crcrx_r[4:0], d};
      end
      if (fe) begin
        pcrc_r <= rem;
      end
      pvalid_r <= live & (pvalid_r | fe);
      errflag_r <= err | (errflag_r & ~(rd_done && (idx == IDX_STAT2)));
      tally_r <= (err && (tally_nxt != 8'hFF)) ? (tally_nxt + 8'h01) : tally_nxt;
    end
  end

  // Overhead work and visible copies
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      {ind_w_r, eoc_w_r, ind_r, eoc_r} <= 52'h0000000000000;
    end else begin
      ind_w_r <= ind_w_nxt;
      eoc_w_r <= eoc_w_nxt;
      if (fe) begin
        ind_r <= ind_w_nxt;
        eoc_r <= eoc_w_nxt;
      end
    end
  end

  // Signal bits and block position
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      {bb_r, sigcnt_r, sigw_r, sig_r} <= 30'h00000000;
    end else if (!live || fe) begin
      bb_r <= 8'h00;
      sigcnt_r <= 6'h00;
    end else if (step && payload) begin
      bb_r <= blk_end ? 8'h00 : (bb_r + 8'h01);
      if (bb_r < {4'h0, cfg_r.sbits}) begin
        sigw_r <= {sigw_r[6:0], d};
      end
      if (blk_end) begin
        sigcnt_r <= sig_upd ? 6'h00 : (sigcnt_r + 6'h01);
      end
      if (sig_upd) begin
        sig_r <= (bb_r < {4'h0, cfg_r.sbits}) ? {sigw_r[6:0], d} : sigw_r;
      end
    end
  end

  // Symbol decode of corrected pairs
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      {sgn_r, quat_r} <= 4'h0;
    end else if (step && live && in_data) begin
      if (!p_r[0]) begin
        sgn_r <= corr;
      end else begin
        quat_r <= quat(sgn_r, corr);
      end
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign RX_FRAME_TICK = tick_r;
endmodule

// [dsl_frame_receiver_chk.sv]
`timescale 1ns/100ps
// Bus timing and frame tick checks at the pins
module dsl_frame_receiver_chk
  import dsl_rx_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic RX_FRAME_TICK
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Word index and whether a register sits there
  wire [7:0] idx = PADDR[9:2];
  wire mapped = idx inside {IDX_OPS_LOW, IDX_CMD1, IDX_CMD2, IDX_BLK_BITS, IDX_SBITS,
    IDX_SYNC, IDX_COMMON1, IDX_RESYNC, IDX_OPS_HIGH, IDX_IND_A, IDX_IND_B, IDX_SIG,
    IDX_STAT1, IDX_STAT2, IDX_TALLY};
  wire rd_done = PREADY && !PWRITE;
  // Setup, one wait state, then the answer
  sequence setup_s; PSEL && !PENABLE; endsequence
  sequence answer_s; !PREADY ##1 PREADY; endsequence
  a_one_wait: assert property (setup_s |=> answer_s) else $error("Ready timing");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("Ready long");
  a_ready_access: assert property (PREADY |-> PSEL && PENABLE) else $error("Ready idle");
  a_err_map: assert property (PREADY |-> PSLVERR == !mapped) else $error("Error flag");
  a_err_ready: assert property (PSLVERR |-> PREADY) else $error("Error alone");
  a_rd_zero:
    assert property (rd_done && (!mapped || idx == IDX_RESYNC) |-> PRDATA == 32'h0)
    else $error("Read not zero");
  a_rd_hold: assert property ($changed(PRDATA) |-> rd_done) else $error("Data moved");
  a_tick_pulse:
    assert property (RX_FRAME_TICK |=> !RX_FRAME_TICK) else $error("Tick long");
endmodule
bind dsl_frame_receiver dsl_frame_receiver_chk u_chk (.CLOCK(CLOCK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_FRAME_TICK(RX_FRAME_TICK));

// [dsl_line_model.sv]
`timescale 1ns/100ps
// Transceiver side: bit clock runs only while a frame is sent
module dsl_line_model (
  output logic bit_clk,
  output logic line_data
);
  initial begin
    bit_clk = 1'b0;
    line_data = 1'b1;
  end
  // One frame, highest bit first, data stable around each rise
  task automatic send(input logic [141:0] f);
    #7;
    for (int i = 141; i >= 0; i--) begin
      line_data = f[i];
      #40 bit_clk = 1'b1;
      #80 bit_clk = 1'b0;
      #40;
    end
    // Released line shows the opposite of its last bit
    line_data = ~line_data;
  endtask
endmodule

// [dsl_frame_receiver_bench.sv]
`timescale 1ns/100ps
// Registers over the bus, frames over the line, step table as model
module dsl_frame_receiver_bench;
  import dsl_rx_pkg::*;
  localparam logic [13:0] pattern = 14'h1E35; // Programmed frame marker
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [9:0] PADDR = 10'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic RX_FRAME_TICK;
  logic bit_clk;
  logic line_data;
  logic [31:0] seed = 32'h000116A4;
  logic [31:0] rd;
  logic er;
  int n_fail = 0;
  int n_tests = 0;
  int ticks = 0;
  logic [5:0] cq = 6'h00; // Model CRC of the frame sent last
  logic [7:0] ie = 8'h00; // Expected visible indicator bits 7:0
  // Per step: marker flip, closing pair, tick due, status mask and value, count
  logic [13:0] xm [8] = '{14'h0, 14'h0, 14'h0, 14'h0, 14'h3FFF, 14'h0, SIGN_MASK, 14'h3FFF};
  logic [1:0] lp [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};
  logic tk [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [7:0] sm [8] = '{8'h77, 8'h77, 8'h77, 8'h77, 8'h30, 8'h37, 8'h77, 8'h30};
  logic [7:0] sv [8] = '{8'h15, 8'h17, 8'h23, 8'h21, 8'h30, 8'h25, 8'h53, 8'h00};
  int cn [8] = '{0, 1, -1, -1, 1, -1, 0, -1};
  // Per step: bad check bits sent and block error due (-1: not compared)
  int ce [8] = '{0, 0, 1, 0, 0, -1, 0, 0};
  dsl_frame_receiver DUT (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .BIT_CLK_IN(bit_clk), .RX_LINE_DATA(line_data),
    .RX_FRAME_TICK(RX_FRAME_TICK));
  dsl_line_model u_line (.bit_clk(bit_clk), .line_data(line_data));
  always #10 CLOCK = ~CLOCK;
  // Count frame ticks
  always @(posedge CLOCK) if (RX_FRAME_TICK === 1'b1) ticks++;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // CRC from the rules: data bits in order, check positions skipped
  function automatic logic [5:0] crc_model(input logic [127:0] v);
    logic [5:0] c;
    c = 6'h00;
    for (int p = 0; p < 128; p++) begin
      if (!(p inside {30, 31, 64, 65, 98, 99})) begin
        c = {c[4:0], 1'b0} ^ ((v[127 - p] ^ c[5]) ? CRC_POLY[5:0] : 6'h00);
      end
    end
    return c;
  endfunction
  task automatic end_sim();
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One bus transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int i;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {idx, 2'b00};
    PWDATA <= wd;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    i = 0;
    do begin
      @(posedge CLOCK);
      i++;
    end while (PREADY !== 1'b1 && i < 20);
    if (PREADY !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask
  // Random payload frame, then tick, status and count against the table
  task automatic frame(input int s);
    logic [127:0] pl;
    logic [127:0] v;
    int t;
    t = ticks;
    for (int j = 0; j < 4; j++) begin
      seed = lfsr(seed);
      pl = {pl[95:0], seed};
    end
    v = {pl[125:0], lp[s]};
    // Check bits carry the previous frame's CRC, spoilt where the table asks
    {v[97], v[96], v[63], v[62], v[29], v[28]} = cq ^ ((ce[s] == 1) ? 6'h01 : 6'h00);
    cq = crc_model(v);
    // Indicator bits at p 66-69 and 100-103, sign bits fixed on a swapped line
    if (tk[s]) ie = {v[61:58], v[27:24]} ^ ((xm[s] == SIGN_MASK) ? 8'hAA : 8'h00);
    u_line.send({pattern ^ xm[s], v});
    @(posedge CLOCK);
    for (int i = 0; i < 20 && ticks == t; i++) @(posedge CLOCK);
    chk("ticks", t + tk[s], ticks);
    apb(1'b0, IDX_STAT1, 32'h0);
    chk("status", sv[s], rd[7:0] & sm[s]);
    apb(1'b0, IDX_STAT2, 32'h0);
    if (cn[s] >= 0) chk("count", cn[s], rd[2:0]);
    if (ce[s] >= 0) chk("errflag", ce[s], {31'h0, rd[5]});
    apb(1'b0, IDX_TALLY, 32'h0);
    if (ce[s] >= 0) chk("tally", ce[s], rd);
    apb(1'b0, IDX_IND_A, 32'h0);
    chk("indicators", {24'h0, ie}, rd);
  endtask
  initial begin
    repeat (10) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    apb(1'b0, IDX_CMD1, 32'h0);
    chk("cmd1", 32'h32, rd);
    apb(1'b0, IDX_CMD2, 32'h0);
    chk("cmd2", 32'h0C, rd);
    apb(1'b0, 8'h00, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, IDX_CMD1, 32'h32);
    apb(1'b1, IDX_SYNC, {18'h0, pattern});
    apb(1'b1, IDX_BLK_BITS, 32'h2);
    apb(1'b1, IDX_RESYNC, 32'h0);
    apb(1'b0, IDX_RESYNC, 32'h0);
    chk("strobe", 32'h0, rd);
    for (int s = 0; s < 8; s++) begin
      if (s == 6) begin
        apb(1'b1, IDX_RESYNC, 32'hA5);
        apb(1'b0, IDX_STAT2, 32'h0);
        chk("resync", 32'h0, rd & 32'h7);
      end
      frame(s);
    end
    end_sim();
  end
endmodule
